/* File: src/csve_pkg.sv */
package csve_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;
  localparam int unsigned REG_W  = 16;

  // printed register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CTRL     = 8'h1a;
  localparam logic [ADDR_W-1:0] IDX_DATA     = 8'h1b;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h21;

  localparam logic [ADDR_W-1:0] ADR_CTRL     = {IDX_CTRL[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_DATA     = {IDX_DATA[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = {IDX_IRQ_STAT[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'b00};

  //////////////////////////////////////////////////////////////////////////////
  // control register layout
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_PER_LO  = 1;
  localparam int unsigned CTRL_PER_HI  = 2;
  localparam int unsigned CTRL_FRZ_BIT = 3;
  localparam int unsigned CTRL_RDY_BIT = 15;
  localparam int unsigned PER_W        = 2;

  localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [REG_W-1:0] DATA_RST = 16'h0000;

  // interrupt status / mask layout
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_RDY_BIT  = 0;
  localparam int unsigned IRQ_DROP_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // timing: one period unit is a fixed count of reference clock cycles
  localparam int unsigned UNIT_TIME_NS   = 1048576;
  localparam int unsigned REF_CLK_NS     = 8;
  localparam int unsigned UNIT_CYCLES    = UNIT_TIME_NS / REF_CLK_NS;
  localparam int unsigned UNITS_PER_STEP = 2;

  // receive error sample and variance sum
  localparam int unsigned SAMPLE_W = 8;
  localparam int unsigned SUM_W    = 32;

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic             rdy;
    logic             freeze;
    logic [PER_W-1:0] period;
    logic             enable;
  } csve_ctrl_t;

  typedef enum logic [0:0] {
    CSVE_BUS_IDLE = 1'b0,
    CSVE_BUS_ACK  = 1'b1
  } csve_bus_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0]   be;
    logic [REG_W-1:0]  wdata;
  } csve_req_t;

endpackage

/* File: src/csve_timer.sv */
`timescale 1ns/1ns
module csve_timer #(
  parameter int unsigned UNIT_CYCLES = csve_pkg::UNIT_CYCLES,
  parameter int unsigned PER_W       = csve_pkg::PER_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [PER_W-1:0] sel,
  output logic                  done
);

  localparam int unsigned CYC_W  = $clog2(UNIT_CYCLES);
  localparam int unsigned UNIT_W = 8;
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(UNIT_CYCLES - 1);

  typedef struct packed {
    logic [CYC_W-1:0]  cyc;
    logic [UNIT_W-1:0] unit;
  } csve_tmr_t;

  csve_tmr_t         s_r;
  csve_tmr_t         s_nxt;
  logic [UNIT_W-1:0] unit_last;
  logic              cyc_end;

  // interval is (sel+1) steps of two units each
  assign unit_last = UNIT_W'((32'(sel) + 32'd1) * csve_pkg::UNITS_PER_STEP - 32'd1);
  assign cyc_end   = (s_r.cyc == CYC_LAST);
  assign done      = run && !restart && cyc_end && (s_r.unit == unit_last);

  always_comb begin
    s_nxt = s_r;
    if (restart || !run) begin
      s_nxt = '0;
    end else if (cyc_end) begin
      s_nxt.cyc  = '0;
      s_nxt.unit = done ? '0 : s_r.unit + 8'h01;
    end else begin
      s_nxt.cyc = s_r.cyc + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // csve_timer

/* File: src/csve_acc.sv */
`timescale 1ns/1ns
module csve_acc #(
  parameter int unsigned SAMPLE_W = csve_pkg::SAMPLE_W,
  parameter int unsigned SUM_W    = csve_pkg::SUM_W
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       clear,
  input  wire logic                       en,
  input  wire logic                       sample_valid,
  input  wire logic signed [SAMPLE_W-1:0] sample,
  output logic             [SUM_W-1:0]    sum
);

  typedef struct packed {
    logic [SUM_W-1:0] sum;
  } csve_acc_st_t;

  csve_acc_st_t              s_r;
  csve_acc_st_t              s_nxt;
  logic signed [2*SAMPLE_W-1:0] sq;
  logic        [SUM_W:0]        wide;
  logic                         take;

  assign sq   = sample * sample;
  assign take = en && sample_valid;
  assign wide = {1'b0, s_r.sum} + (SUM_W+1)'(unsigned'(sq));
  assign sum  = s_r.sum;

  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      // sample of the boundary cycle opens the new interval
      s_nxt.sum = take ? SUM_W'(unsigned'(sq)) : '0;
    end else if (take) begin
      // saturate: a wrapped sum would read as a clean line
      s_nxt.sum = wide[SUM_W] ? {SUM_W{1'b1}} : wide[SUM_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // csve_acc

/* File: src/cable_snr_variance_estimator.sv */
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
// Behaviour
// - the variance figure is built only from the 100 Mb receive path error samples.
// - accumulation runs only while the enable bit 0 of control is set, which resets to 0.
// - period field bits 2:1 choose 2, 4, 6 or 8 ms, resetting to 0.
// - each nominal millisecond is counted as 2^17 reference clock cycles.
// - a write of a new period value discards the running sum and restarts the interval.
// - the readable sum is loaded only when the selected period elapses.
// - the read-only ready flag at bit 15 sets when a fresh result is loaded, reset 0.
// - ready clears after two consecutive reads of the data register.
// - while freeze bit 3 is set no new result is loaded into the data register.
// - freeze clears after two consecutive reads of the data register, reset 0.
// - control bits 14:4 read as zero and ignore writes.
// - the result is a 32-bit sum seen through one 16-bit read-only data register, reset 0.
// - after freeze is set the first data read gives the low half, the second the high half.
module cable_snr_variance_estimator #(
  parameter int unsigned UNIT_CYCLES = csve_pkg::UNIT_CYCLES,
  parameter int unsigned SAMPLE_W    = csve_pkg::SAMPLE_W
) (
  input  wire logic                                  CLK,
  input  wire logic                                  SRST,
  input  wire logic                                  RX_LINK_100,
  input  wire logic                                  RX_ERR_VALID,
  input  wire logic signed [SAMPLE_W-1:0]            RX_ERR,
  input  wire logic        [csve_pkg::ADDR_W-1:0]    AVS_ADDRESS,
  input  wire logic                                  AVS_READ,
  input  wire logic                                  AVS_WRITE,
  input  wire logic        [csve_pkg::BE_W-1:0]      AVS_BYTEENABLE,
  input  wire logic        [csve_pkg::DATA_W-1:0]    AVS_WRITEDATA,
  output logic             [csve_pkg::DATA_W-1:0]    AVS_READDATA,
  output logic                                       AVS_WAITREQUEST,
  output logic                                       IRQ
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    csve_pkg::csve_bus_t                bus;
    logic [csve_pkg::DATA_W-1:0]        rdata;
    csve_pkg::csve_ctrl_t               ctrl;
    logic                               half;
    logic [csve_pkg::SUM_W-1:0]         sum;
    logic [csve_pkg::IRQ_W-1:0]         irq_stat;
    logic [csve_pkg::IRQ_W-1:0]         irq_mask;
  } csve_state_t;

  csve_state_t                  s_r;
  csve_state_t                  s_nxt;
  csve_pkg::csve_req_t          req;
  logic                         run;
  logic                         restart;
  logic                         per_write;
  logic                         period_done;
  logic [csve_pkg::SUM_W-1:0]   acc_sum;
  logic [csve_pkg::IRQ_W-1:0]   irq_set;
  logic [csve_pkg::IRQ_W-1:0]   irq_clr;
  logic                         accept;
  logic [csve_pkg::PER_W-1:0]   wr_period;
  logic                         wr_freeze;
  logic                         wr_enable;

  //////////////////////////////////////////////////////////////////////////////
  // request bundle and bus handshake
  assign req.rd    = AVS_READ;
  assign req.wr    = AVS_WRITE;
  assign req.addr  = AVS_ADDRESS;
  assign req.be    = AVS_BYTEENABLE;
  assign req.wdata = AVS_WRITEDATA[csve_pkg::REG_W-1:0];

  // every access takes one wait cycle, answered on the second edge
  assign accept          = (req.rd || req.wr) && (s_r.bus == csve_pkg::CSVE_BUS_ACK);
  assign AVS_WAITREQUEST = (req.rd || req.wr) && (s_r.bus == csve_pkg::CSVE_BUS_IDLE);
  assign AVS_READDATA    = s_r.rdata;
  assign IRQ             = |(s_r.irq_stat & s_r.irq_mask);

  // control write fields, taken from the low byte lane
  assign wr_enable = req.wdata[csve_pkg::CTRL_EN_BIT];
  assign wr_period = req.wdata[csve_pkg::CTRL_PER_HI:csve_pkg::CTRL_PER_LO];
  assign wr_freeze = req.wdata[csve_pkg::CTRL_FRZ_BIT];

  assign per_write = accept && req.wr && (req.addr == csve_pkg::ADR_CTRL) && req.be[0]
                     && (wr_period != s_r.ctrl.period);

  //////////////////////////////////////////////////////////////////////////////
  // measurement path
  // link loss or disable restarts, so a partial interval never reports
  assign run     = s_r.ctrl.enable && RX_LINK_100;
  assign restart = per_write || !run;

  csve_timer #(
    .UNIT_CYCLES (UNIT_CYCLES),
    .PER_W       (csve_pkg::PER_W)
  ) u_timer (
    .clk     (CLK),
    .srst    (SRST),
    .run     (run),
    .restart (restart),
    .sel     (s_r.ctrl.period),
    .done    (period_done)
  );

  csve_acc #(
    .SAMPLE_W (SAMPLE_W),
    .SUM_W    (csve_pkg::SUM_W)
  ) u_acc (
    .clk          (CLK),
    .srst         (SRST),
    .clear        (restart || period_done),
    .en           (run),
    .sample_valid (RX_ERR_VALID),
    .sample       (RX_ERR),
    .sum          (acc_sum)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt   = s_r;
    irq_set = '0;
    irq_clr = '0;

    // read mux sampled in the wait cycle
    if (s_r.bus == csve_pkg::CSVE_BUS_IDLE) begin
      if (req.rd || req.wr) begin
        s_nxt.bus = csve_pkg::CSVE_BUS_ACK;
      end
      if (req.rd) begin
        // only a read replaces the data, so it holds until the next read captures
        s_nxt.rdata = '0;
        case (req.addr)
          csve_pkg::ADR_CTRL: begin
            // reserved bits stay zero
            s_nxt.rdata[csve_pkg::CTRL_RDY_BIT] = s_r.ctrl.rdy;
            s_nxt.rdata[csve_pkg::CTRL_FRZ_BIT] = s_r.ctrl.freeze;
            s_nxt.rdata[csve_pkg::CTRL_PER_HI:csve_pkg::CTRL_PER_LO] = s_r.ctrl.period;
            s_nxt.rdata[csve_pkg::CTRL_EN_BIT]  = s_r.ctrl.enable;
          end
          csve_pkg::ADR_DATA: begin
            s_nxt.rdata[csve_pkg::REG_W-1:0] = s_r.half
                ? s_r.sum[csve_pkg::SUM_W-1:csve_pkg::REG_W]
                : s_r.sum[csve_pkg::REG_W-1:0];
          end
          csve_pkg::ADR_IRQ_STAT: begin
            s_nxt.rdata[csve_pkg::IRQ_W-1:0] = s_r.irq_stat;
          end
          csve_pkg::ADR_IRQ_MASK: begin
            s_nxt.rdata[csve_pkg::IRQ_W-1:0] = s_r.irq_mask;
          end
          default: begin
            s_nxt.rdata = '0;
          end
        endcase
      end
    end else begin
      s_nxt.bus = csve_pkg::CSVE_BUS_IDLE;
    end

    // side effects at the answering edge
    if (accept && req.wr) begin
      case (req.addr)
        csve_pkg::ADR_CTRL: begin
          if (req.be[0]) begin
            s_nxt.ctrl.enable = wr_enable;
            s_nxt.ctrl.period = wr_period;
            s_nxt.ctrl.freeze = wr_freeze;
            if (wr_freeze && !s_r.ctrl.freeze) begin
              s_nxt.half = 1'b0;
            end
          end
        end
        csve_pkg::ADR_IRQ_STAT: begin
          if (req.be[0]) begin
            irq_clr = req.wdata[csve_pkg::IRQ_W-1:0];
          end
        end
        csve_pkg::ADR_IRQ_MASK: begin
          if (req.be[0]) begin
            s_nxt.irq_mask = req.wdata[csve_pkg::IRQ_W-1:0];
          end
        end
        default: begin
          s_nxt.irq_mask = s_nxt.irq_mask;
        end
      endcase
    end

    if (accept && req.rd && (req.addr == csve_pkg::ADR_DATA)) begin
      if (!s_r.half) begin
        s_nxt.half = 1'b1;
      end else begin
        s_nxt.half        = 1'b0;
        s_nxt.ctrl.rdy    = 1'b0;
        s_nxt.ctrl.freeze = 1'b0;
      end
    end

    // result load; freeze as it stood before this edge decides
    if (period_done) begin
      if (s_r.ctrl.freeze) begin
        irq_set[csve_pkg::IRQ_DROP_BIT] = 1'b1;
      end else begin
        s_nxt.sum      = acc_sum;
        s_nxt.ctrl.rdy = 1'b1;
        irq_set[csve_pkg::IRQ_RDY_BIT] = 1'b1;
      end
    end

    // set wins over a clear in the same cycle
    s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (SRST) begin
      s_r.bus      <= csve_pkg::CSVE_BUS_IDLE;
      s_r.rdata    <= '0;
      s_r.ctrl     <= csve_pkg::CTRL_RST[4:0];
      s_r.half     <= 1'b0;
      s_r.sum      <= {csve_pkg::DATA_RST, csve_pkg::DATA_RST};
      s_r.irq_stat <= csve_pkg::IRQ_RST;
      s_r.irq_mask <= csve_pkg::IRQ_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // cable_snr_variance_estimator

/* File: sim/csve_checker.sv */
`timescale 1ns/1ns
module csve_checker (
  input wire logic                        CLK,
  input wire logic                        SRST,
  input wire logic [csve_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic                        AVS_READ,
  input wire logic                        AVS_WRITE,
  input wire logic [csve_pkg::BE_W-1:0]   AVS_BYTEENABLE,
  input wire logic [csve_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [csve_pkg::DATA_W-1:0] AVS_READDATA,
  input wire logic                        AVS_WAITREQUEST,
  input wire logic                        IRQ
);
  logic                       req;
  logic                       rd_wait_s;
  logic [csve_pkg::IRQ_W-1:0] mask_r;
  logic [csve_pkg::IRQ_W-1:0] mask_nxt;

  assign req       = AVS_READ || AVS_WRITE;
  assign rd_wait_s = AVS_READ && AVS_WAITREQUEST;

  // shadow mask, updated on the accepting edge just as the register is
  always_comb begin
    mask_nxt = mask_r;
    if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
        && AVS_ADDRESS == csve_pkg::ADR_IRQ_MASK) begin
      mask_nxt = AVS_WRITEDATA[csve_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_r <= csve_pkg::IRQ_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking dc @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence req_wait;
    req && AVS_WAITREQUEST;
  endsequence
  sequence ctrl_take;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == csve_pkg::ADR_CTRL;
  endsequence

  wait_first_a: assert property (req && !$past(req) |-> AVS_WAITREQUEST)
    else $error("new request answered without a wait state");
  wait_one_a: assert property (req_wait |=> !AVS_WAITREQUEST)
    else $error("more than one wait state");
  bus_idle_a: assert property (!req |-> !AVS_WAITREQUEST)
    else $error("waitrequest without a request");
  upper_zero_a: assert property (AVS_READDATA[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  resv_zero_a: assert property (ctrl_take |-> AVS_READDATA[14:4] == 11'h000)
    else $error("control reserved bits not zero");
  rdata_hold_a: assert property ($changed(AVS_READDATA) |-> $past(rd_wait_s))
    else $error("read data changed outside a read");
  reset_zero_a: assert property ($fell(SRST) |-> !IRQ && AVS_READDATA == 32'h0)
    else $error("outputs not cleared by reset");
  irq_mask_a: assert property (mask_r == 2'h0 |-> !IRQ)
    else $error("interrupt raised while fully masked");
endmodule // csve_checker

bind cable_snr_variance_estimator csve_checker csve_checker_i (
  .CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ)
);

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
  // short unit keeps every period between 32 and 128 cycles
  localparam int unsigned UNITS = 16;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [3:0]  be;
    logic [15:0] d;
  } csve_row_t;

  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        link = 1'b1;
  logic        vld = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [15:0] q;
  logic [15:0] ctl;
  int          failures = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  csve_row_t rows [11] = '{
    '{1'b0, csve_pkg::ADR_CTRL, 4'hf, 16'h0000},
    '{1'b0, csve_pkg::ADR_DATA, 4'hf, 16'h0000},
    '{1'b1, csve_pkg::ADR_CTRL, 4'h1, 16'hfffe},
    '{1'b0, csve_pkg::ADR_CTRL, 4'hf, 16'h000e},
    '{1'b1, csve_pkg::ADR_CTRL, 4'h0, 16'h0001},
    '{1'b0, csve_pkg::ADR_CTRL, 4'hf, 16'h000e},
    '{1'b1, csve_pkg::ADR_CTRL, 4'h1, 16'h0000},
    '{1'b1, csve_pkg::ADR_DATA, 4'h1, 16'hffff},
    '{1'b0, 8'h40, 4'hf, 16'h0000},
    '{1'b1, csve_pkg::ADR_IRQ_MASK, 4'h1, 16'h0003},
    '{1'b0, csve_pkg::ADR_IRQ_MASK, 4'hf, 16'h0003}
  };

  // error sample 8'h9c is -100, so every accepted cycle adds 10000
  cable_snr_variance_estimator #(.UNIT_CYCLES(UNITS)) cable_snr_variance_estimator_i (
    .CLK(clk), .SRST(srst), .RX_LINK_100(link), .RX_ERR_VALID(vld), .RX_ERR(8'h9c),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq)
  );

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one clear edge after release, so the next request never lands in the same step
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= {16'h0000, d};
    // waits as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    // one wait state, so the answer comes on the second edge
    chk("wait_states", 32'd2, 32'(n));
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, 4'hf);
    chk(nm, {16'h0000, e}, {16'h0000, q});
  endtask

  task automatic pair(input logic [31:0] s);
    rd("sum_low", csve_pkg::ADR_DATA, s[15:0]);
    rd("sum_high", csve_pkg::ADR_DATA, s[31:16]);
  endtask

  // polling adds up to a few cycles, hence the window
  task automatic wait_rdy(input int n);
    int t0;
    int k;
    t0 = cyc;
    k = 0;
    do begin
      bus(1'b0, csve_pkg::ADR_CTRL, 16'h0000, 4'hf);
      k++;
    end while (q[15] !== 1'b1 && k < 100);
    chk("ready_time", 32'h1, {31'h0, cyc - t0 >= n - 2 && cyc - t0 <= n + 8});
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (40) @(posedge clk);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, rows[i].be);
      if (!rows[i].w) begin
        chk("row", {16'h0000, rows[i].d}, {16'h0000, q});
      end
    end
    wr(csve_pkg::ADR_CTRL, 16'h0001);
    wait_rdy(2 * UNITS);
    chk("irq_ready", 32'h1, {31'h0, irq});
    wr(csve_pkg::ADR_CTRL, 16'h0009);
    // boundary sample opens the next interval, so one opened by enable is one short
    pair((2 * UNITS - 1) * 32'h2710);
    rd("ctrl_paired", csve_pkg::ADR_CTRL, 16'h0001);
    wr(csve_pkg::ADR_CTRL, 16'h0000);
    wr(csve_pkg::ADR_IRQ_MASK, 16'h0000);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(csve_pkg::ADR_IRQ_MASK, 16'h0001);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(csve_pkg::ADR_IRQ_STAT, 16'h0001);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    // frozen across two completions: both are dropped
    wr(csve_pkg::ADR_CTRL, 16'h0009);
    repeat (4 * UNITS + 8) @(posedge clk);
    link <= 1'b0;
    rd("ctrl_frozen", csve_pkg::ADR_CTRL, 16'h0009);
    rd("stat_drop", csve_pkg::ADR_IRQ_STAT, 16'h0002);
    pair((2 * UNITS - 1) * 32'h2710);
    rd("ctrl_thawed", csve_pkg::ADR_CTRL, 16'h0001);
    wr(csve_pkg::ADR_IRQ_STAT, 16'h0002);
    link <= 1'b1;
    // 20 cycles banked before each period change must be thrown away
    for (int p = 1; p < 4; p++) begin
      wr(csve_pkg::ADR_CTRL, 16'h0001);
      repeat (20) @(posedge clk);
      ctl = 16'h0001;
      ctl[2:1] = p[1:0];
      wr(csve_pkg::ADR_CTRL, ctl);
      wait_rdy((p + 1) * 2 * UNITS);
      wr(csve_pkg::ADR_CTRL, ctl | 16'h0008);
      pair((p + 1) * 2 * UNITS * 32'h2710);
    end
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd("ctrl_reset", csve_pkg::ADR_CTRL, 16'h0000);
    rd("data_reset", csve_pkg::ADR_DATA, 16'h0000);
    // no valid samples: the interval still completes, with an empty sum
    vld <= 1'b0;
    wr(csve_pkg::ADR_CTRL, 16'h0001);
    wait_rdy(2 * UNITS);
    wr(csve_pkg::ADR_CTRL, 16'h0009);
    pair(32'h0000_0000);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule // tb
